// file: logic/ee_defs.vh
// Constants for the two-wire serial memory slave.
// Assumes a 125 MHz ref_clk; the pins are sampled, never used as clocks.
// Contract
// - Data falling while clock high is a start; every command begins with one.
// - Data rising while clock high is a stop; every operation ends with one.
// - Data changes only while clock low; one bit per clock pulse.
// - Addressed receiver acknowledges each byte on a ninth clock from the master.
// - No acknowledge at all while the internal write cycle runs.
// - Acknowledger holds data low for the whole acknowledge clock high phase.
// - After the master withholds acknowledge, the device releases data high.
// - First byte after start is control: code 1010, three selects, direction.
// - Acknowledge control only on code match and selects equal to select pins.
// - Direction bit one means read, zero means write.
// - Byte write: control, word address into pointer, one data byte, each acknowledged.
// - Stop after write data starts the self-timed write cycle.
// - Under write protection bytes are still acknowledged but the array is unchanged.
// - A protected write still takes the full write cycle time.
// - Page write takes up to fifteen more bytes, held until stop.
// - Each data byte increments only the low four pointer bits.
// - Over sixteen bytes wrap and overwrite; only the last sixteen are kept.
// - Page write past a boundary wraps to the start of that page.
// - Write-protect high protects the whole array; low permits all writes.
// - Low supply detector inhibits all array writes.
// - Sequential read never leaves this device's own 256 bytes.
// - Write cycle ends within five milliseconds after the stop.
`ifndef EE_DEFS_VH
`define EE_DEFS_VH
`define EE_DEV_CODE 4'ha
`define EE_CLK_MHZ 125
`define EE_TWC_MS 5
`define EE_TWC_CYC (`EE_TWC_MS * 1000 * `EE_CLK_MHZ)
`define EE_ARRAY_BYTES 256
`define EE_PAGE_BYTES 16
`define EE_ERASED 8'hff
`endif

// file: logic/ee_pin_sync.v
// Three-stage sampler for pins from outside the ref_clk domain.
// A level is accepted only once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module ee_pin_sync #(
  parameter integer WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Pins and filtered levels
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_ff
);
  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  integer i;

  always @(posedge ref_clk) begin
    if (rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      level_ff <= RST_VAL;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
        // One-cycle glitches never reach the protocol logic
        if (s2_ff[i] == s3_ff[i]) begin
          level_ff[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule // ee_pin_sync
`default_nettype wire

// file: logic/ee_array.v
// Byte array in flip-flops: one write port, combinational read.
// Assumes the caller serialises writes one byte per cycle.
`timescale 1ns/1ns
`default_nettype none
`include "ee_defs.vh"
module ee_array #(
  parameter integer DEPTH = `EE_ARRAY_BYTES
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Write port
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  // Read port
  input wire [7:0] rd_addr,
  output wire [7:0] rd_data
);
  reg [7:0] mem_ff [0:DEPTH-1];
  integer i;

  assign rd_data = mem_ff[rd_addr];

  always @(posedge ref_clk) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= `EE_ERASED;
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end
endmodule // ee_array
`default_nettype wire

// file: logic/ee_slave.v
// Two-wire slave of a 256-byte memory: addressing, byte/page write,
// timed write cycle, write protect, supply inhibit, sequential read.
// Assumes scl/sda are pin levels; sda is open drain, driven low only.
`timescale 1ns/1ns
`default_nettype none
`include "ee_defs.vh"
module ee_slave #(
  parameter integer WC_CYCLES = `EE_TWC_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Two-wire bus
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_ff,
  output reg sda_oe_n_ff,
  // Straps and supply monitor
  input wire select_pin_low,
  input wire select_pin_mid,
  input wire select_pin_high,
  input wire write_protect_in,
  input wire supply_low_in,
  // Status
  output reg write_busy_ff
);
  // ==========================================
  // States and phases
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_ACK1 = 3'h2;
  localparam [2:0] ST_ACK2 = 3'h3;
  localparam [2:0] ST_TX = 3'h4;
  localparam [2:0] ST_TXACK = 3'h5;
  localparam [2:0] ST_TXW = 3'h6;
  localparam [1:0] PH_CTRL = 2'h0;
  localparam [1:0] PH_ADDR = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;
  localparam [19:0] WC_LAST = WC_CYCLES[19:0] - 20'h00001;

  // ==========================================
  // Pin sampling
  wire [6:0] lvl;
  wire scl_f = lvl[0];
  wire sda_f = lvl[1];
  wire wp_f = lvl[2];
  wire low_f = lvl[3];
  wire [2:0] sel_f = lvl[6:4];

  ee_pin_sync #(.WIDTH(7), .RST_VAL(7'h0f)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in({select_pin_high, select_pin_mid, select_pin_low,
             supply_low_in, write_protect_in, sda_in, scl_in}),
    .level_ff(lvl)
  );

  reg scl_q_ff;
  reg sda_q_ff;
  wire scl_rise = scl_f & ~scl_q_ff;
  wire scl_fall = ~scl_f & scl_q_ff;
  wire start_det = scl_f & scl_q_ff & sda_q_ff & ~sda_f;
  wire stop_det = scl_f & scl_q_ff & ~sda_q_ff & sda_f;

  // ==========================================
  // State
  reg [2:0] state_ff;
  reg [1:0] phase_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg ack_ok_ff;
  reg [7:0] addr_ff;
  reg [7:0] pbuf_ff [0:15];
  reg [15:0] valid_ff;
  reg [19:0] wc_cnt_ff;
  reg [4:0] cidx_ff;
  reg wp_lat_ff;
  integer i;

  wire [7:0] rx_byte = {shift_ff[6:0], sda_f};
  wire [7:0] rd_data;

  // Commit walks the page buffer one byte per cycle inside the timed window
  wire wr_en = write_busy_ff & ~cidx_ff[4] & valid_ff[cidx_ff[3:0]]
               & ~wp_lat_ff & ~low_f;

  ee_array u_array (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_en),
    .wr_addr({addr_ff[7:4], cidx_ff[3:0]}),
    .wr_data(pbuf_ff[cidx_ff[3:0]]),
    .rd_addr(addr_ff),
    .rd_data(rd_data)
  );

  // ==========================================
  // Protocol engine
  always @(posedge ref_clk) begin
    if (rst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      sda_out_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      write_busy_ff <= 1'b0;
      state_ff <= ST_IDLE;
      phase_ff <= PH_CTRL;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      ack_ok_ff <= 1'b0;
      addr_ff <= 8'h00;
      valid_ff <= 16'h0000;
      wc_cnt_ff <= 20'h00000;
      cidx_ff <= 5'h00;
      wp_lat_ff <= 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
        pbuf_ff[i] <= 8'h00;
      end
    end else begin
      scl_q_ff <= scl_f;
      sda_q_ff <= sda_f;
      sda_out_ff <= 1'b0;
      // Write cycle timer; protected writes run the full time too
      if (write_busy_ff) begin
        if (!cidx_ff[4]) begin
          cidx_ff <= cidx_ff + 5'h01;
        end
        wc_cnt_ff <= wc_cnt_ff + 20'h00001;
        if (wc_cnt_ff == WC_LAST) begin
          write_busy_ff <= 1'b0;
          valid_ff <= 16'h0000;
        end
      end
      if (start_det) begin
        state_ff <= ST_RX;
        phase_ff <= PH_CTRL;
        bit_cnt_ff <= 3'h0;
        sda_oe_n_ff <= 1'b1;
      end else if (stop_det) begin
        state_ff <= ST_IDLE;
        sda_oe_n_ff <= 1'b1;
        if (phase_ff == PH_DATA && valid_ff != 16'h0000 && !write_busy_ff) begin
          write_busy_ff <= 1'b1;
          wc_cnt_ff <= 20'h00000;
          cidx_ff <= 5'h00;
          wp_lat_ff <= wp_f;
        end
      end else begin
        case (state_ff)
          ST_RX: begin
            if (scl_rise) begin
              shift_ff <= rx_byte;
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              if (bit_cnt_ff == 3'h7) begin
                state_ff <= ST_ACK1;
                ack_ok_ff <= 1'b1;
                case (phase_ff)
                  PH_CTRL: begin
                    if (rx_byte[7:4] != `EE_DEV_CODE || rx_byte[3:1] != sel_f) begin
                      state_ff <= ST_IDLE;
                    end
                    ack_ok_ff <= ~write_busy_ff;
                  end
                  PH_ADDR: begin
                    addr_ff <= rx_byte;
                    valid_ff <= 16'h0000;
                  end
                  default: begin
                    // Low nibble only: page wrap, last sixteen win
                    pbuf_ff[addr_ff[3:0]] <= rx_byte;
                    valid_ff[addr_ff[3:0]] <= 1'b1;
                    addr_ff[3:0] <= addr_ff[3:0] + 4'h1;
                  end
                endcase
              end
            end
          end
          ST_ACK1: begin
            if (scl_fall) begin
              sda_oe_n_ff <= ~ack_ok_ff;
              state_ff <= ST_ACK2;
            end
          end
          ST_ACK2: begin
            if (scl_fall) begin
              sda_oe_n_ff <= 1'b1;
              bit_cnt_ff <= 3'h0;
              state_ff <= ST_RX;
              if (!ack_ok_ff) begin
                state_ff <= ST_IDLE;
              end else if (phase_ff == PH_CTRL) begin
                if (shift_ff[0]) begin
                  shift_ff <= rd_data;
                  sda_oe_n_ff <= rd_data[7];
                  state_ff <= ST_TX;
                end else begin
                  phase_ff <= PH_ADDR;
                end
              end else begin
                phase_ff <= PH_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              if (bit_cnt_ff == 3'h7) begin
                // Full 8-bit wrap keeps reads inside this device
                addr_ff <= addr_ff + 8'h01;
                state_ff <= ST_TXACK;
              end
            end else if (scl_fall) begin
              shift_ff <= {shift_ff[6:0], 1'b1};
              sda_oe_n_ff <= shift_ff[6];
            end
          end
          ST_TXACK: begin
            if (scl_fall) begin
              sda_oe_n_ff <= 1'b1;
            end else if (scl_rise) begin
              state_ff <= sda_f ? ST_IDLE : ST_TXW;
            end
          end
          ST_TXW: begin
            if (scl_fall) begin
              shift_ff <= rd_data;
              sda_oe_n_ff <= rd_data[7];
              bit_cnt_ff <= 3'h0;
              state_ff <= ST_TX;
            end
          end
          default: begin
            sda_oe_n_ff <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // ee_slave
`default_nettype wire

// file: tb/ee_bus_master.sv
// Bus master model that drives the clock and data lines of the memory slave.
// Assumes the bench resolves the open-drain data wire, with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module ee_bus_master (
  // Clock and resolved wire
  input wire logic ref_clk,
  input wire logic sda_line,
  // Driven lines
  output var logic scl,
  output var logic sda_drv
);
  // ==========
  // Bus timing
  // The clock idles high between frames.
  // One bit is 64 ns: low 6, high 2 ref_clk cycles. The long low phase
  // lets the slave's sampled answer settle before the rise.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_drv = b;
    w(4);
    scl = 1'b1;
    w(2);
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic start();
    w(2);
    sda_drv = 1'b1;
    w(8);
    scl = 1'b1;
    w(6);
    sda_drv = 1'b0;
    w(6);
    scl = 1'b0;
  endtask
  task automatic stop();
    w(2);
    sda_drv = 1'b0;
    w(8);
    scl = 1'b1;
    w(6);
    sda_drv = 1'b1;
    w(12);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // ee_bus_master
`default_nettype wire

// file: tb/ee_slave_assertions.sv
// Checker on the ports of ee_slave.
// Assumes one ref_clk domain and a synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
module ee_slave_chk #(
  parameter integer WC_CYCLES = 625000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out_ff,
  input wire logic sda_oe_n_ff,
  input wire logic write_busy_ff
);
  // ==========
  // Helper count of busy cycles
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  assign nxt_busy_cnt = write_busy_ff ? busy_cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_cnt_ff <= 32'h0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_lines_idle;
    scl_in && sda_in;
  endsequence
  sequence s_busy_run;
    write_busy_ff [*8];
  endsequence
  property p_busy_len;
    $fell(write_busy_ff) |-> busy_cnt_ff >= WC_CYCLES - 1 && busy_cnt_ff <= WC_CYCLES + 1;
  endproperty
  // ==========
  // Properties
  a_busy_start: assert property ($rose(write_busy_ff) |-> s_lines_idle)
    else $error("write cycle began without a stop");
  a_busy_hold: assert property ($rose(write_busy_ff) |=> s_busy_run)
    else $error("write cycle cut short");
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
  a_busy_max: assert property (busy_cnt_ff <= WC_CYCLES + 1)
    else $error("write cycle overran");
  a_no_ack_busy: assert property (write_busy_ff |-> sda_oe_n_ff)
    else $error("data pulled during write cycle");
  a_drive_low: assert property (!sda_oe_n_ff |-> !sda_out_ff)
    else $error("data driven high");
  a_change_low: assert property ($changed(sda_oe_n_ff) |-> !scl_in)
    else $error("data changed while clock high");
  // Eight samples low: one whole 64 ns bit, covering the clock high phase
  a_ack_span: assert property ($fell(sda_oe_n_ff) |=> !sda_oe_n_ff [*7])
    else $error("low level released too early");
endmodule // ee_slave_chk
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the two-wire memory slave.
// Assumes ee_bus_master drives the bus; the data wire has a pull-up.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam integer WC = 200;
  logic ref_clk, rst, wp, low_vcc, ack;
  logic [2:0] sel;
  logic [7:0] rd [16];
  wire logic scl, sda_drv, sda_bus, sda_out, sda_oe_n, busy;
  int bad_count, cmp_count;
  assign sda_bus = sda_drv & (sda_oe_n | sda_out);
  ee_bus_master u_mst (.ref_clk(ref_clk), .sda_line(sda_bus), .scl(scl), .sda_drv(sda_drv));
  ee_slave #(.WC_CYCLES(WC)) u_dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda_bus), .sda_out_ff(sda_out), .sda_oe_n_ff(sda_oe_n),
    .select_pin_low(sel[0]), .select_pin_mid(sel[1]), .select_pin_high(sel[2]),
    .write_protect_in(wp), .supply_low_in(low_vcc), .write_busy_ff(busy));
  // ==========
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0);
    int t;
    u_mst.start();
    u_mst.put({4'ha, sel, 1'b0}, ack);
    chk({7'h0, ack}, 8'h1);
    u_mst.put(a, ack);
    chk({7'h0, ack}, 8'h1);
    for (int k = 0; k < n; k++) begin
      u_mst.put(d0 + 8'(k), ack);
      chk({7'h0, ack}, 8'h1);
    end
    u_mst.stop();
    chk({7'h0, busy}, 8'h1);
    // Polling during the cycle must go unanswered
    u_mst.start();
    u_mst.put({4'ha, sel, 1'b0}, ack);
    chk({7'h0, ack}, 8'h0);
    u_mst.stop();
    t = 0;
    while (busy !== 1'b0 && t < WC) begin
      u_mst.w(1);
      t++;
    end
    chk({7'h0, busy}, 8'h0);
  endtask
  task automatic rd_seq(input logic [7:0] a, input int n);
    u_mst.start();
    u_mst.put({4'ha, sel, 1'b0}, ack);
    u_mst.put(a, ack);
    u_mst.start();
    u_mst.put({4'ha, sel, 1'b1}, ack);
    chk({7'h0, ack}, 8'h1);
    for (int k = 0; k < n; k++) u_mst.get(k == n - 1, rd[k]);
    u_mst.stop();
  endtask
  // ==========
  // Scenarios
  task automatic t_byte();
    wr(8'h25, 1, 8'h5a);
    rd_seq(8'h25, 1);
    chk(rd[0], 8'h5a);
  endtask
  task automatic t_page();
    // Eighteen bytes from offset e wrap once over slots e and f
    wr(8'h3e, 18, 8'h80);
    rd_seq(8'h30, 16);
    for (int s = 0; s < 16; s++) chk(rd[s], 8'h82 + 8'(s));
    rd_seq(8'h40, 1);
    chk(rd[0], 8'hff);
  endtask
  task automatic t_guard();
    wp = 1'b1;
    wr(8'h25, 1, 8'ha5);
    wp = 1'b0;
    low_vcc = 1'b1;
    wr(8'h25, 1, 8'hc3);
    low_vcc = 1'b0;
    rd_seq(8'h25, 1);
    chk(rd[0], 8'h5a);
  endtask
  task automatic t_roll();
    // Pointer runs from the last byte back to byte zero
    wr(8'h00, 1, 8'h77);
    rd_seq(8'hff, 2);
    chk(rd[0], 8'hff);
    chk(rd[1], 8'h77);
  endtask
  task automatic t_select();
    sel = 3'h5;
    u_mst.start();
    u_mst.put(8'ha0, ack);
    chk({7'h0, ack}, 8'h0);
    u_mst.put(8'h25, ack);
    chk({7'h0, ack}, 8'h0);
    u_mst.start();
    u_mst.put({4'hb, sel, 1'b0}, ack);
    chk({7'h0, ack}, 8'h0);
    u_mst.stop();
    wr(8'h41, 1, 8'h11);
    rd_seq(8'h41, 1);
    chk(rd[0], 8'h11);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========
  // Clock, sequence and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    low_vcc = 1'b0;
    sel = 3'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (10) @(negedge ref_clk);
    t_byte();
    t_page();
    t_guard();
    t_roll();
    t_select();
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end
endmodule // tb_top
bind ee_slave ee_slave_chk #(.WC_CYCLES(WC_CYCLES)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out_ff(sda_out_ff), .sda_oe_n_ff(sda_oe_n_ff),
  .write_busy_ff(write_busy_ff));
`default_nettype wire
